// File: hw/cmd_pkg.sv
// constants, encodings and state type for the host command decoder
package cmd_pkg;
  localparam logic [7:0] CMD_WR       = 8'h00;
  localparam logic [7:0] CMD_OR       = 8'h01;
  localparam logic [7:0] CMD_AND      = 8'h02;
  localparam logic [7:0] CMD_WR_MULTI = 8'h03;
  localparam logic [7:0] CMD_RD       = 8'h04;
  localparam logic [7:0] CMD_RD_MULTI = 8'h05;
  localparam logic [7:0] CMD_EE_WR    = 8'h06;
  localparam logic [7:0] CMD_EE_RD    = 8'h07;
  localparam logic [7:0] CMD_TX_LOAD  = 8'h08;
  localparam logic [7:0] ACT_WR       = 8'h01;
  localparam logic [7:0] ACT_OR       = 8'h02;
  localparam logic [7:0] ACT_AND      = 8'h03;
  localparam int         REG_AW       = 6;
  localparam int         REG_DEPTH    = 64;
  localparam logic [7:0] REG_COUNT    = 8'h30;
  localparam logic [8:0] MULTI_MAX    = 9'h02a;
  localparam logic [8:0] RD_MULTI_MAX = 9'h012;
  localparam logic [8:0] RD_MAX       = 9'h001;
  localparam int         ALIST_AW     = 5;
  localparam int         ALIST_DEPTH  = 18;
  localparam int         EE_AW        = 8;
  localparam int         EE_DEPTH     = 255;
  localparam logic [7:0] EE_LAST      = 8'hfe;
  localparam logic [8:0] EE_MAX_LEN   = 9'h0ff;
  localparam logic [8:0] EE_SPAN      = 9'h0ff;
  localparam int         TX_AW        = 9;
  localparam int         TX_DEPTH     = 260;
  localparam logic [8:0] TX_MAX       = 9'h104;
  localparam logic [2:0] POS_LAST_VAL = 3'h4;
  localparam logic [2:0] POS_DONE     = 3'h5;
  localparam logic [2:0] POS_ENT_LAST = 3'h5;
  localparam logic [2:0] POS_SAT      = 3'h7;
  localparam logic [2:0] EXC_NONE     = 3'h0;
  localparam logic [2:0] EXC_BAD_CMD  = 3'h1;
  localparam logic [2:0] EXC_BAD_REG  = 3'h2;
  localparam logic [2:0] EXC_BAD_CNT  = 3'h3;
  localparam logic [2:0] EXC_BAD_ADDR = 3'h4;
  localparam logic [2:0] EXC_TX_BUSY  = 3'h5;
  localparam logic [2:0] EXC_BAD_ACT  = 3'h6;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CMD   = 6'h02,
    ST_PARAM = 6'h04,
    ST_DRAIN = 6'h08,
    ST_RWAIT = 6'h10,
    ST_RESP  = 6'h20
  } state_t;
endpackage : cmd_pkg

// File: hw/byte_ram.sv
// simple memory with one write port and one registered read port
`timescale 1ns/1ps
module byte_ram #(
  parameter int DW    = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_r;

  assign rdata = rdata_r;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (re) begin
      rdata_r <= mem[raddr];
    end
  end
endmodule : byte_ram

// File: hw/spi_byte_slave.sv
// spi mode 0 byte slave with pin synchronisers and edge detection
`timescale 1ns/1ps
module spi_byte_slave (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       nss_b,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            frame_start,
  output logic            frame_end,
  output logic            tx_load,
  output logic            miso,
  output logic            miso_oe
);
  logic       sck_s1_r, sck_s2_r, sck_s3_r;
  logic       mosi_s1_r, mosi_s2_r;
  logic       nss_s1_r, nss_s2_r, nss_s3_r;
  logic [2:0] cnt_r;
  logic [7:0] rx_sh_r, rx_byte_r, tx_sh_r;
  logic       rx_valid_r, fs_r, fe_r, tx_load_r, miso_r, miso_oe_r;
  wire        sel   = !nss_s2_r;
  wire        fs    = nss_s3_r & !nss_s2_r;
  wire        fe    = !nss_s3_r & nss_s2_r;
  wire        rise  = sel & sck_s2_r & !sck_s3_r;
  wire        fall  = sel & !sck_s2_r & sck_s3_r;
  wire        load  = fs | (fall & (cnt_r == 3'h0));
  wire  [7:0] rx_in = {rx_sh_r[6:0], mosi_s2_r};

  assign rx_valid    = rx_valid_r;
  assign rx_byte     = rx_byte_r;
  assign frame_start = fs_r;
  assign frame_end   = fe_r;
  assign tx_load     = tx_load_r;
  assign miso        = miso_r;
  assign miso_oe     = miso_oe_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
      {mosi_s1_r, mosi_s2_r}         <= 2'h0;
      {nss_s1_r, nss_s2_r, nss_s3_r} <= 3'h7;
    end else begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= {sck, sck_s1_r, sck_s2_r};
      {mosi_s1_r, mosi_s2_r}         <= {mosi, mosi_s1_r};
      {nss_s1_r, nss_s2_r, nss_s3_r} <= {nss_b, nss_s1_r, nss_s2_r};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= 3'h0;
      rx_sh_r    <= 8'h00;
      rx_byte_r  <= 8'h00;
      tx_sh_r    <= 8'h00;
      rx_valid_r <= 1'b0;
      fs_r       <= 1'b0;
      fe_r       <= 1'b0;
      tx_load_r  <= 1'b0;
      miso_r     <= 1'b0;
      miso_oe_r  <= 1'b0;
    end else begin
      fs_r       <= fs;
      fe_r       <= fe;
      tx_load_r  <= load;
      miso_oe_r  <= sel;
      rx_valid_r <= rise & (cnt_r == 3'h7);
      if (fs) begin
        cnt_r <= 3'h0;
      end else if (rise) begin
        cnt_r   <= cnt_r + 3'h1;
        rx_sh_r <= rx_in;
        if (cnt_r == 3'h7) begin
          rx_byte_r <= rx_in;
        end
      end
      if (load) begin
        tx_sh_r <= tx_byte;
        miso_r  <= tx_byte[7];
      end else if (fall) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        miso_r  <= tx_sh_r[6];
      end
    end
  end
endmodule : spi_byte_slave

// File: hw/host_register_eeprom_cmd_decoder.sv
// host command decoder: register, eeprom and transmit buffer commands over spi
`timescale 1ns/1ps
// How it works
// (R1) code 01: read register, OR with four-byte mask, write back
// (R2) code 02: read register, AND with four-byte mask, write back
// (R3) any register access to a missing address raises an exception
// (R4) code 03 batch holds at most 42 entries, processed in given order
// (R5) batch entry is address, action, then four value bytes low first
// (R6) batch action 01 writes, 02 ORs, 03 ANDs, chosen per entry
// (R7) exception mid batch keeps earlier updates, no rollback
// (R8) code 04 returns the addressed register as four bytes
// (R9) batch read returns only values, in the order addresses came
// (R10) batch read with under one or over eighteen addresses is an exception
// (R11) code 06 writes data bytes to eeprom from start address upward
// (R12) eeprom write start above 254 or count outside 1..255 is an exception
// (R13) code 07 returns length eeprom bytes from start address upward
// (R14) eeprom read reaching past 254 or bad start is an exception
// (R15) code 08 loads payload into 260-byte transmit buffer, no answer
// (R16) buffer load with 0 or over 260 bytes, or during sending, is an exception
// (R17) host starts sending separately; loading never starts transmission
// (R18) four-byte parameters travel least significant byte first
// (R19) exceptions raise the interrupt line and record the cause
// (R20) host holds select low for whole frame, command byte first
// (R21) first frame byte is the command; unknown codes raise an exception
module host_register_eeprom_cmd_decoder
  import cmd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             sck,
  input  wire logic             mosi,
  input  wire logic             nss_b,
  output logic                  miso,
  output logic                  miso_oe,
  input  wire logic             rf_tx_busy,
  input  wire logic             irq_clear,
  output logic                  irq,
  output logic      [2:0]       exc_cause,
  output logic      [8:0]       tx_len,
  input  wire logic [TX_AW-1:0] tx_rd_addr,
  output logic      [7:0]       tx_rd_data
);
  function automatic logic [31:0] apply_action(input logic [7:0]  act,
                                               input logic [31:0] old,
                                               input logic [31:0] v);
    unique case (act)
      ACT_OR:  apply_action = old | v;
      ACT_AND: apply_action = old & v;
      default: apply_action = v;
    endcase
  endfunction : apply_action

  function automatic logic reg_exists(input logic [7:0] a);
    reg_exists = (a < REG_COUNT);
  endfunction : reg_exists

  state_t      st_r, st_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [7:0]  act_r, act_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [2:0]  pos_r, pos_nxt;
  logic [8:0]  cnt_r, cnt_nxt;
  logic [31:0] val_r, val_nxt;
  logic [31:0] word_r, word_nxt;
  logic [8:0]  left_r, left_nxt;
  logic [4:0]  widx_r, widx_nxt;
  logic [1:0]  bsel_r, bsel_nxt;
  logic [7:0]  eptr_r, eptr_nxt;
  logic        ee_r, ee_nxt;
  logic        f1_r, f2_r;
  logic        irq_r;
  logic [2:0]  cause_r;
  logic [8:0]  tx_len_r, tx_len_nxt;
  logic        busy_s1_r, busy_s2_r;
  logic        exc_set;
  logic [2:0]  exc_code;
  logic        param_rd, reg_we, ee_we, tx_we, al_we;
  logic        fetch_go;
  logic [4:0]  fetch_idx;
  logic [7:0]  fetch_eaddr;

  wire         rx_valid, frame_start, frame_end, tx_load;
  wire  [7:0]  rx_b;
  wire  [31:0] reg_rdata;
  wire  [7:0]  al_rdata, ee_rdata;
  wire  [31:0] val_full  = {rx_b, val_r[31:8]}; // [R18] [R5]
  wire  [31:0] reg_wdata = apply_action(act_r, reg_rdata, val_full);
  wire  [2:0]  pos_inc   = (pos_r == POS_SAT) ? pos_r : pos_r + 3'h1;
  wire  [8:0]  cnt_inc   = cnt_r + 9'h001;
  wire  [8:0]  ee_sum    = {1'b0, addr_r} + cnt_r;
  wire         ee_in     = (ee_sum <= {1'b0, EE_LAST});
  wire         rd_fetch  = f1_r & !ee_r;
  wire         reg_re    = param_rd | rd_fetch;
  wire  [REG_AW-1:0] reg_raddr = rd_fetch ? al_rdata[REG_AW-1:0] : rx_b[REG_AW-1:0];
  wire         resp_on   = (st_r == ST_RWAIT) || (st_r == ST_RESP);
  wire  [7:0]  tx_byte   = (resp_on && left_r != 9'h000) ? word_r[{bsel_r, 3'b000} +: 8]
                                                          : 8'h00;
  wire  [8:0]  rd_limit  = (cmd_r == CMD_RD_MULTI) ? RD_MULTI_MAX : RD_MAX;

  assign irq       = irq_r;
  assign exc_cause = cause_r;
  assign tx_len    = tx_len_r;

  spi_byte_slave u_spi (
    .clk         (clk),
    .rst_b       (rst_b),
    .sck         (sck),
    .mosi        (mosi),
    .nss_b       (nss_b),
    .tx_byte     (tx_byte),
    .rx_valid    (rx_valid),
    .rx_byte     (rx_b),
    .frame_start (frame_start),
    .frame_end   (frame_end),
    .tx_load     (tx_load),
    .miso        (miso),
    .miso_oe     (miso_oe)
  );

  byte_ram #(.DW(32), .DEPTH(REG_DEPTH), .AW(REG_AW)) u_regs (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (reg_we),
    .waddr (addr_r[REG_AW-1:0]),
    .wdata (reg_wdata),
    .re    (reg_re),
    .raddr (reg_raddr),
    .rdata (reg_rdata)
  );

  byte_ram #(.DW(8), .DEPTH(ALIST_DEPTH), .AW(ALIST_AW)) u_alist (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (al_we),
    .waddr (cnt_r[ALIST_AW-1:0]),
    .wdata (rx_b),
    .re    (fetch_go),
    .raddr (fetch_idx),
    .rdata (al_rdata)
  );

  byte_ram #(.DW(8), .DEPTH(EE_DEPTH), .AW(EE_AW)) u_eeprom (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (ee_we),
    .waddr (ee_sum[EE_AW-1:0]),
    .wdata (rx_b),
    .re    (fetch_go),
    .raddr (fetch_eaddr),
    .rdata (ee_rdata)
  );

  byte_ram #(.DW(8), .DEPTH(TX_DEPTH), .AW(TX_AW)) u_txbuf (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (tx_we),
    .waddr (cnt_r),
    .wdata (rx_b),
    .re    (1'b1),
    .raddr (tx_rd_addr),
    .rdata (tx_rd_data)
  );

  always_comb begin
    st_nxt      = st_r;
    cmd_nxt     = cmd_r;
    act_nxt     = act_r;
    addr_nxt    = addr_r;
    pos_nxt     = pos_r;
    cnt_nxt     = cnt_r;
    val_nxt     = val_r;
    left_nxt    = left_r;
    widx_nxt    = widx_r;
    bsel_nxt    = bsel_r;
    eptr_nxt    = eptr_r;
    ee_nxt      = ee_r;
    tx_len_nxt  = tx_len_r;
    exc_set     = 1'b0;
    exc_code    = EXC_NONE;
    param_rd    = 1'b0;
    reg_we      = 1'b0;
    ee_we       = 1'b0;
    tx_we       = 1'b0;
    al_we       = 1'b0;
    fetch_go    = 1'b0;
    fetch_idx   = widx_r;
    fetch_eaddr = eptr_r;
    unique case (st_r)
      ST_IDLE: begin
        if (frame_start) begin
          st_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (frame_end) begin
          st_nxt = ST_IDLE;
        end else if (rx_valid) begin
          cmd_nxt = rx_b; // [R20] [R21]
          pos_nxt = 3'h0;
          cnt_nxt = 9'h000;
          act_nxt = (rx_b == CMD_OR) ? ACT_OR : (rx_b == CMD_AND) ? ACT_AND : ACT_WR;
          st_nxt  = ST_PARAM;
          if (rx_b == CMD_TX_LOAD && busy_s2_r) begin
            exc_set  = 1'b1; // [R16]
            exc_code = EXC_TX_BUSY;
            st_nxt   = ST_DRAIN;
          end else if (rx_b > CMD_TX_LOAD) begin
            exc_set  = 1'b1; // [R21]
            exc_code = EXC_BAD_CMD;
            st_nxt   = ST_DRAIN;
          end
        end
      end
      ST_PARAM: begin
        if (frame_end) begin
          st_nxt = ST_IDLE;
          unique case (cmd_r)
            CMD_WR, CMD_OR, CMD_AND: begin
              exc_set = (pos_r < POS_DONE);
            end
            CMD_WR_MULTI: begin
              exc_set = (pos_r != 3'h0) || (cnt_r == 9'h000);
            end
            CMD_RD, CMD_RD_MULTI: begin
              if (cnt_r == 9'h000) begin
                exc_set = 1'b1; // [R10]
              end else begin
                left_nxt  = {cnt_r[6:0], 2'b00}; // [R8] [R9]
                widx_nxt  = 5'h00;
                bsel_nxt  = 2'h0;
                ee_nxt    = 1'b0;
                fetch_go  = 1'b1;
                fetch_idx = 5'h00;
                st_nxt    = ST_RWAIT;
              end
            end
            CMD_EE_WR: begin
              exc_set = (pos_r == 3'h0) || (cnt_r == 9'h000); // [R12]
            end
            CMD_EE_RD: begin
              if (pos_r < 3'h2) begin
                exc_set = 1'b1;
              end else if (ee_sum > EE_SPAN) begin
                exc_set  = 1'b1; // [R14]
                exc_code = EXC_BAD_ADDR;
              end else if (cnt_r != 9'h000) begin
                left_nxt    = cnt_r; // [R13]
                eptr_nxt    = addr_r;
                bsel_nxt    = 2'h0;
                ee_nxt      = 1'b1;
                fetch_go    = 1'b1;
                fetch_eaddr = addr_r;
                st_nxt      = ST_RWAIT;
              end
            end
            default: begin
              if (cnt_r == 9'h000) begin
                exc_set = 1'b1; // [R16]
              end else begin
                tx_len_nxt = cnt_r; // [R15] [R17]
              end
            end
          endcase
          if (exc_code == EXC_NONE) begin
            exc_code = EXC_BAD_CNT;
          end
        end else if (rx_valid) begin
          unique case (cmd_r)
            CMD_WR, CMD_OR, CMD_AND: begin
              pos_nxt = pos_inc;
              if (pos_r == 3'h0) begin
                if (!reg_exists(rx_b)) begin
                  exc_set  = 1'b1; // [R3]
                  exc_code = EXC_BAD_REG;
                  st_nxt   = ST_DRAIN;
                end else begin
                  addr_nxt = rx_b;
                  param_rd = 1'b1; // [R1] [R2]
                end
              end else if (pos_r < POS_LAST_VAL) begin
                val_nxt = val_full;
              end else if (pos_r == POS_LAST_VAL) begin
                reg_we = 1'b1; // [R1] [R2]
              end
            end
            CMD_WR_MULTI: begin
              pos_nxt = (pos_r == POS_ENT_LAST) ? 3'h0 : pos_r + 3'h1;
              if (pos_r == 3'h0) begin
                addr_nxt = rx_b;
                param_rd = 1'b1;
                if (cnt_r == MULTI_MAX) begin
                  exc_set  = 1'b1; // [R4]
                  exc_code = EXC_BAD_CNT;
                  st_nxt   = ST_DRAIN;
                end else if (!reg_exists(rx_b)) begin
                  exc_set  = 1'b1; // [R3] [R7]
                  exc_code = EXC_BAD_REG;
                  st_nxt   = ST_DRAIN;
                end
              end else if (pos_r == 3'h1) begin
                act_nxt = rx_b; // [R6]
                if (rx_b < ACT_WR || rx_b > ACT_AND) begin
                  exc_set  = 1'b1; // [R7]
                  exc_code = EXC_BAD_ACT;
                  st_nxt   = ST_DRAIN;
                end
              end else if (pos_r < POS_ENT_LAST) begin
                val_nxt = val_full;
              end else begin
                reg_we  = 1'b1; // [R4] [R6]
                cnt_nxt = cnt_inc;
              end
            end
            CMD_RD, CMD_RD_MULTI: begin
              if (cnt_r == rd_limit) begin
                exc_set  = (cmd_r == CMD_RD_MULTI); // [R10]
                exc_code = EXC_BAD_CNT;
                st_nxt   = exc_set ? ST_DRAIN : ST_PARAM;
              end else if (!reg_exists(rx_b)) begin
                exc_set  = 1'b1; // [R3]
                exc_code = EXC_BAD_REG;
                st_nxt   = ST_DRAIN;
              end else begin
                al_we   = 1'b1; // [R9]
                cnt_nxt = cnt_inc;
              end
            end
            CMD_EE_WR, CMD_EE_RD: begin
              pos_nxt = pos_inc;
              if (pos_r == 3'h0) begin
                addr_nxt = rx_b;
                if (rx_b > EE_LAST) begin
                  exc_set  = 1'b1; // [R12] [R14]
                  exc_code = EXC_BAD_ADDR;
                  st_nxt   = ST_DRAIN;
                end
              end else if (cmd_r == CMD_EE_RD) begin
                if (pos_r == 3'h1) begin
                  cnt_nxt = {1'b0, rx_b};
                end
              end else if (cnt_r == EE_MAX_LEN) begin
                exc_set  = 1'b1; // [R12]
                exc_code = EXC_BAD_CNT;
                st_nxt   = ST_DRAIN;
              end else begin
                ee_we   = ee_in; // [R11]
                cnt_nxt = cnt_inc;
              end
            end
            default: begin
              if (cnt_r == TX_MAX) begin
                exc_set  = 1'b1; // [R16]
                exc_code = EXC_BAD_CNT;
                st_nxt   = ST_DRAIN;
              end else begin
                tx_we   = 1'b1; // [R15]
                cnt_nxt = cnt_inc;
              end
            end
          endcase
        end
      end
      ST_DRAIN: begin
        if (frame_end) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RWAIT: begin
        if (frame_start) begin
          st_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        if (frame_end) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
    if (resp_on && tx_load && left_r != 9'h000) begin
      left_nxt = left_r - 9'h001;
      if (ee_r) begin
        eptr_nxt    = eptr_r + 8'h01; // [R13]
        fetch_go    = 1'b1;
        fetch_eaddr = eptr_nxt;
      end else begin
        bsel_nxt = bsel_r + 2'h1; // [R18]
        if (bsel_r == 2'h3) begin
          widx_nxt  = widx_r + 5'h01; // [R9]
          fetch_go  = 1'b1;
          fetch_idx = widx_nxt;
        end
      end
    end
  end

  wire        irq_nxt   = exc_set | (irq_r & !irq_clear); // [R19]
  wire  [2:0] cause_nxt = exc_set ? exc_code : (irq_clear ? EXC_NONE : cause_r);

  always_comb begin
    word_nxt = word_r;
    if (f1_r && ee_r) begin
      word_nxt = {24'h000000, ee_rdata};
    end else if (f2_r) begin
      word_nxt = reg_rdata; // [R8]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= ST_IDLE;
      cmd_r     <= 8'h00;
      act_r     <= 8'h00;
      addr_r    <= 8'h00;
      pos_r     <= 3'h0;
      cnt_r     <= 9'h000;
      val_r     <= 32'h00000000;
      word_r    <= 32'h00000000;
      left_r    <= 9'h000;
      widx_r    <= 5'h00;
      bsel_r    <= 2'h0;
      eptr_r    <= 8'h00;
      ee_r      <= 1'b0;
      f1_r      <= 1'b0;
      f2_r      <= 1'b0;
      irq_r     <= 1'b0;
      cause_r   <= EXC_NONE;
      tx_len_r  <= 9'h000;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      cmd_r     <= cmd_nxt;
      act_r     <= act_nxt;
      addr_r    <= addr_nxt;
      pos_r     <= pos_nxt;
      cnt_r     <= cnt_nxt;
      val_r     <= val_nxt;
      word_r    <= word_nxt;
      left_r    <= left_nxt;
      widx_r    <= widx_nxt;
      bsel_r    <= bsel_nxt;
      eptr_r    <= eptr_nxt;
      ee_r      <= ee_nxt;
      f1_r      <= fetch_go;
      f2_r      <= rd_fetch;
      irq_r     <= irq_nxt;
      cause_r   <= cause_nxt;
      tx_len_r  <= tx_len_nxt;
      busy_s1_r <= rf_tx_busy;
      busy_s2_r <= busy_s1_r;
    end
  end
endmodule : host_register_eeprom_cmd_decoder

// File: test/cmd_sva.sv
// port checks for the command decoder
`timescale 1ns/1ps
module cmd_sva
  import cmd_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sck,
  input wire logic       nss_b,
  input wire logic       miso,
  input wire logic       miso_oe,
  input wire logic       irq_clear,
  input wire logic       irq,
  input wire logic [2:0] exc_cause,
  input wire logic [8:0] tx_len
);
  logic [4:0] idle_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) idle_r <= 5'h00;
    else if (!nss_b) idle_r <= 5'h00;
    else if (idle_r != 5'h1f) idle_r <= idle_r + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  irq_sticky_a: assert property (irq && !irq_clear |=> irq)
    else $error("irq lost");
  cause_irq_a: assert property (irq == (exc_cause != EXC_NONE))
    else $error("cause and irq differ");
  cause_code_a: assert property (exc_cause <= EXC_BAD_ACT)
    else $error("bad cause");
  idle_clear_a: assert property (idle_r > 5'h0f && irq_clear |=> !irq)
    else $error("clear ignored");
  irq_source_a: assert property ($rose(irq) |-> idle_r < 5'h10)
    else $error("irq outside frame");
  tx_len_a: assert property ($changed(tx_len) |->
    nss_b && idle_r < 5'h10 && tx_len != 9'h000 && tx_len <= TX_MAX)
    else $error("bad length update");
  oe_idle_a: assert property (nss_b [*6] |-> !miso_oe)
    else $error("oe while idle");
  miso_quiet_a: assert property (!miso_oe |-> !miso)
    else $error("miso not quiet");
  miso_hold_a: assert property (sck && $past(sck) |-> $stable(miso))
    else $error("miso moved");
  cover property ($rose(irq));
  cover property ($changed(tx_len));
  cover property ($rose(miso));
endmodule : cmd_sva
bind host_register_eeprom_cmd_decoder cmd_sva i_cmd_sva (.clk, .rst_b, .sck, .nss_b,
  .miso, .miso_oe, .irq_clear, .irq, .exc_cause, .tx_len);

// File: test/spi_host.sv
// host model: spi mode 0 master sending whole frames
`timescale 1ns/1ps
module spi_host #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sck,
  output logic      mosi,
  output logic      nss_b
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    nss_b = 1'b1;
  end
  // select low for the whole frame, msb first, command byte first
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    nss_b <= 1'b0;
    repeat (8) @(posedge clk);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi <= tx[i][k];
        repeat (HALF) @(posedge clk);
        b[k] = miso;
        sck <= 1'b1;
        repeat (HALF) @(posedge clk);
        sck <= 1'b0;
      end
      rx.push_back(b);
    end
    repeat (HALF) @(posedge clk);
    nss_b <= 1'b1;
    mosi <= ~mosi;
    repeat (12) @(posedge clk);
  endtask : frame
endmodule : spi_host

// File: test/tb_host_register_eeprom_cmd_decoder.sv
// self-checking bench for the host command decoder
`timescale 1ns/1ps
module tb_host_register_eeprom_cmd_decoder;
  import cmd_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             rf_tx_busy = 1'b0;
  logic             irq_clear = 1'b0;
  logic [TX_AW-1:0] tx_rd_addr = 9'h000;
  logic             sck, mosi, nss_b, miso, miso_oe, irq;
  logic [2:0]       exc_cause;
  logic [8:0]       tx_len;
  logic [7:0]       tx_rd_data;
  logic [31:0]      regs [64];
  logic [7:0]       ee [256];
  logic [7:0]       q [$], r [$], ad [$];
  logic [31:0]      v;
  int               errors = 0;
  int               num_checks = 0;
  int               s, a;
  always #12.5 clk = ~clk;
  host_register_eeprom_cmd_decoder i_host_register_eeprom_cmd_decoder (.clk, .rst_b,
    .sck, .mosi, .nss_b, .miso, .miso_oe, .rf_tx_busy, .irq_clear, .irq, .exc_cause,
    .tx_len, .tx_rd_addr, .tx_rd_data);
  spi_host i_spi_host (.clk, .miso, .sck, .mosi, .nss_b);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  function automatic logic [31:0] w(input int i);
    return {r[i+3], r[i+2], r[i+1], r[i]};
  endfunction : w
  task automatic fr;
    i_spi_host.frame(q, r);
  endtask : fr
  task automatic resp(input int n);
    q = {};
    repeat (n) q.push_back(8'h00);
    fr;
  endtask : resp
  task automatic ent(input int k, input int d, input logic [31:0] x);
    q.push_back(8'(d));
    q.push_back(8'(k + 1));
    for (int i = 0; i < 4; i++) q.push_back(x[8*i+:8]);
    case (k)
      0: regs[d] = x;
      1: regs[d] = regs[d] | x;
      default: regs[d] = regs[d] & x;
    endcase
  endtask : ent
  task automatic rd(input int d);
    q = {CMD_RD, 8'(d)};
    fr;
    resp(4);
    check(w(0), regs[d]);
  endtask : rd
  task automatic bad(input logic [2:0] c);
    fr;
    repeat (8) @(posedge clk);
    check(irq, 1'b1);
    check(exc_cause, c);
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    @(posedge clk);
    $display("test done: exception %0d", c);
  endtask : bad
  initial begin
    v = $urandom(32'h63ebcca3);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    q = {CMD_WR_MULTI};
    for (int i = 0; i < 42; i++) ent(0, i, $urandom);
    fr;
    for (int i = 42; i < 48; i++) begin
      q = {CMD_WR};
      ent(0, i, $urandom);
      q.delete(2);
      fr;
    end
    for (int k = 0; k < 3; k++) begin
      a = $urandom_range(47);
      q = {};
      ent(k, a, $urandom);
      q[1] = q[0];
      q[0] = 8'(k);
      fr;
      rd(a);
    end
    q = {CMD_WR_MULTI};
    for (int i = 0; i < 6; i++) ent($urandom_range(2), 5 + i % 2, $urandom);
    fr;
    rd(5);
    rd(6);
    q = {CMD_RD_MULTI};
    for (int i = 0; i < 18; i++) q.push_back(8'($urandom_range(47)));
    ad = q;
    fr;
    resp(72);
    for (int i = 0; i < 18; i++) check(w(4 * i), regs[ad[i+1]]);
    $display("test done: registers");
    s = $urandom_range(200);
    q = {CMD_EE_WR, 8'(s)};
    for (int i = 0; i < 8; i++) ee[s+i] = 8'($urandom);
    for (int i = 0; i < 8; i++) q.push_back(ee[s+i]);
    fr;
    q = {CMD_EE_RD, 8'(s), 8'h08};
    fr;
    resp(8);
    for (int i = 0; i < 8; i++) check(r[i], ee[s+i]);
    ee[254] = 8'($urandom);
    q = {CMD_EE_WR, EE_LAST, ee[254]};
    fr;
    q = {CMD_EE_RD, EE_LAST, 8'h01};
    fr;
    resp(1);
    check(r[0], ee[254]);
    $display("test done: eeprom");
    q = {CMD_TX_LOAD, 8'($urandom), 8'($urandom), 8'($urandom)};
    fr;
    check(tx_len, 9'h003);
    for (int i = 0; i < 3; i++) begin
      tx_rd_addr <= 9'(i);
      repeat (2) @(posedge clk);
      check(tx_rd_data, q[i+1]);
    end
    $display("test done: transmit buffer");
    rf_tx_busy <= 1'b1;
    bad(EXC_TX_BUSY);
    rf_tx_busy <= 1'b0;
    check(tx_len, 9'h003);
    q = {CMD_WR_MULTI};
    ent(0, 4, $urandom);
    v = regs[4];
    ent(0, 48, $urandom);
    bad(EXC_BAD_REG);
    regs[4] = v;
    rd(4);
    q = {CMD_RD, REG_COUNT};
    bad(EXC_BAD_REG);
    q = {8'h09};
    bad(EXC_BAD_CMD);
    q = {CMD_EE_WR, 8'hff, 8'h00};
    bad(EXC_BAD_ADDR);
    q = {CMD_EE_RD, EE_LAST, 8'h02};
    bad(EXC_BAD_ADDR);
    q = {CMD_RD_MULTI};
    bad(EXC_BAD_CNT);
    finish_test;
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule : tb_host_register_eeprom_cmd_decoder
